/* svop_regs.svh */
// Purpose: Register offsets, field positions, reset values and timing counts
//          of the sensor video output port.
// Assumes: 8-bit registers reached by an 8-bit register index.
// Notes:   Bit positions inside the registers are local choices.
`ifndef SVOP_REGS_SVH
`define SVOP_REGS_SVH

// Register offsets
`define SVOP_OFF_INTEG_CFG    8'h15
`define SVOP_OFF_TRAIL_ADJ    8'h51
`define SVOP_OFF_SYNC_OFFS    8'h52
`define SVOP_OFF_SYNC_CFG     8'h53
`define SVOP_OFF_SHIFT_CFG    8'h54
`define SVOP_OFF_FLOAT_CFG    8'h55
`define SVOP_OFF_ROW_STATUS   8'h56

// Reset values
`define SVOP_RST_INTEG_CFG    8'h08
`define SVOP_RST_TRAIL_ADJ    8'h08
`define SVOP_RST_SYNC_OFFS    8'h00
`define SVOP_RST_SYNC_CFG     8'h0C
`define SVOP_RST_SHIFT_CFG    8'hF0
`define SVOP_RST_FLOAT_CFG    8'h00

// Field positions
`define SVOP_BIT_PFI          3
`define SVOP_BIT_PCLK_STYLE   0
`define SVOP_BIT_ROW_STYLE    1
`define SVOP_BIT_ROW_POL      2
`define SVOP_BIT_FRAME_POL    3
`define SVOP_BIT_FRAME_STYLE  4
`define SVOP_BIT_MASTER       5
`define SVOP_BIT_PCLK_INV     6
`define SVOP_BIT_DARK_PIX     2
`define SVOP_BIT_BUS_ON       7
`define SVOP_BIT_FLOAT        0
`define SVOP_LSB_ROW_OFS      0
`define SVOP_LSB_FRAME_OFS    4

// Timing counts
`define SVOP_TRIG_BASE_CYC    9'd146
`define SVOP_TRIG_PFI_CYC     9'd37
`define SVOP_TRIG_DARK_CYC    9'd8
`define SVOP_SYNC_PULSE_SLOTS 3'd4

`endif

/* svop_pkg.sv */
// Purpose: Types of the sensor video output port.
// Assumes: Constants live in svop_regs.svh.
// Notes:   Types only.
package svop_pkg;

   // Slave-mode row trigger sequencer
   typedef enum logic [0:0] {TRG_IDLE, TRG_WAIT} svop_trig_t;

   // Offset field of one sync channel
   typedef logic [2:0] svop_ofs_t;

endpackage

/* svop_video_port.sv */
// Purpose: Digital video output port: pixel bus, pixel clock, row and frame
//          sync generation, slave-mode trigger inputs and config registers.
// Assumes: mclk 50 MHz; line_clk2x runs at twice the internal line clock,
//          so one pixel slot is two line_clk2x cycles.
// Notes:   Config reaches the link side through per-bit two-flop synchronisers;
//          change it only while the stream is idle.
`timescale 1ns/10ps
`include "svop_regs.svh"

//Function
//- Float data bus on pin or float bit
//- Bus off drives data lines low
//- Sync outputs float and switch off likewise
//- Barrel shifter maps pixel data to pins
//- Sync pins start in slave mode
//- Style 0: pixel clock free running
//- Style 1: one pulse per valid word
//- Reset default: free, active high clock
//- Row level mode spans row pixels
//- Row pulse mode: four-slot end pulse
//- Row polarity bit; edges on active clock
//- Row edges at first/last pixel, offsettable
//- Frame level mode spans frame pixels
//- Frame pulse: four-slot end pulse, polarity
//- Frame edges at first/last pixel, offsettable
//- Slave mode: trigger-started, no partial integration
//- First pixel 146+37pfi-8dark after trigger
//- Row trigger level follows row polarity
//- Frame trigger clears row address counter
//- Partial integration bit set after reset; inactive until master mode
module svop_video_port
   import svop_pkg::*;
#(
   parameter int PIX_W = 10,
   parameter int ROW_W = 9
)
(
   input  wire logic             mclk,
   input  wire logic             reset_n,
   input  wire logic             line_clk2x,
   input  wire logic [7:0]       reg_addr,
   input  wire logic [7:0]       reg_wdata,
   input  wire logic             reg_wr,
   output logic      [7:0]       reg_rdata,
   input  wire logic             bus_drive_en,
   input  wire logic             px_valid,
   output logic                  px_ready,
   input  wire logic [PIX_W-1:0] px_data,
   input  wire logic             px_row_first,
   input  wire logic             px_row_last,
   input  wire logic             px_frame_first,
   input  wire logic             px_frame_last,
   output logic      [PIX_W-1:0] pix_o,
   output logic                  pix_oe,
   output logic                  pclk_o,
   output logic                  pclk_oe,
   input  wire logic             row_sync_i,
   output logic                  row_sync_o,
   output logic                  row_sync_oe,
   input  wire logic             frame_sync_i,
   output logic                  frame_sync_o,
   output logic                  frame_sync_oe,
   output logic                  row_go,
   output logic                  frame_go,
   output logic      [ROW_W-1:0] row_addr,
   output logic                  pfi_active
);

   ////////////////////////////////////////////////////////////////////////////
   // Register file (mclk)
   logic [7:0]       integ_cfg_reg;
   logic [7:0]       trail_adj_reg;
   logic [7:0]       sync_offs_reg;
   logic [7:0]       sync_cfg_reg;
   logic [7:0]       shift_cfg_reg;
   logic [7:0]       float_cfg_reg;
   logic [ROW_W-1:0] row_addr_reg;

   // Writes land in one cycle; unmapped offsets are ignored
   always_ff @(posedge mclk or negedge reset_n)
   begin
      if (!reset_n)
      begin
         integ_cfg_reg <= `SVOP_RST_INTEG_CFG;
         trail_adj_reg <= `SVOP_RST_TRAIL_ADJ;
         sync_offs_reg <= `SVOP_RST_SYNC_OFFS;
         sync_cfg_reg  <= `SVOP_RST_SYNC_CFG;
         shift_cfg_reg <= `SVOP_RST_SHIFT_CFG;
         float_cfg_reg <= `SVOP_RST_FLOAT_CFG;
      end
      else if (reg_wr)
      begin
         case (reg_addr)
            `SVOP_OFF_INTEG_CFG: integ_cfg_reg <= reg_wdata;
            `SVOP_OFF_TRAIL_ADJ: trail_adj_reg <= reg_wdata;
            `SVOP_OFF_SYNC_OFFS: sync_offs_reg <= reg_wdata;
            `SVOP_OFF_SYNC_CFG:  sync_cfg_reg  <= reg_wdata;
            `SVOP_OFF_SHIFT_CFG: shift_cfg_reg <= reg_wdata;
            `SVOP_OFF_FLOAT_CFG: float_cfg_reg <= reg_wdata;
            default:             ;
         endcase
      end
   end

   // Registered read data, zero for unmapped offsets
   always_ff @(posedge mclk or negedge reset_n)
   begin
      if (!reset_n)
         reg_rdata <= 8'h00;
      else
      begin
         case (reg_addr)
            `SVOP_OFF_INTEG_CFG:  reg_rdata <= integ_cfg_reg;
            `SVOP_OFF_TRAIL_ADJ:  reg_rdata <= trail_adj_reg;
            `SVOP_OFF_SYNC_OFFS:  reg_rdata <= sync_offs_reg;
            `SVOP_OFF_SYNC_CFG:   reg_rdata <= sync_cfg_reg;
            `SVOP_OFF_SHIFT_CFG:  reg_rdata <= shift_cfg_reg;
            `SVOP_OFF_FLOAT_CFG:  reg_rdata <= float_cfg_reg;
            `SVOP_OFF_ROW_STATUS: reg_rdata <= row_addr_reg[7:0];
            default:              reg_rdata <= 8'h00;
         endcase
      end
   end

   logic master_m;
   assign master_m   = sync_cfg_reg[`SVOP_BIT_MASTER];
   // Partial integration has no meaning while triggers pace the rows
   assign pfi_active = integ_cfg_reg[`SVOP_BIT_PFI] & master_m;

   ////////////////////////////////////////////////////////////////////////////
   // Slave-mode trigger inputs (mclk)
   logic [1:0]  rtrig_sync;
   logic [1:0]  ftrig_sync;
   logic        rtrig_prev;
   logic        ftrig_prev;
   logic        rtrig_act;
   logic        ftrig_act;
   logic        rtrig_fall;
   logic        ftrig_fall;

   // Two flops before any logic looks at the pins
   always_ff @(posedge mclk or negedge reset_n)
   begin
      if (!reset_n)
      begin
         rtrig_sync <= 2'b00;
         ftrig_sync <= 2'b00;
      end
      else
      begin
         rtrig_sync <= {rtrig_sync[0], row_sync_i};
         ftrig_sync <= {ftrig_sync[0], frame_sync_i};
      end
   end

   // Active level follows the sync polarity bits
   assign rtrig_act  = ~(rtrig_sync[1] ^ sync_cfg_reg[`SVOP_BIT_ROW_POL]) & ~master_m;
   assign ftrig_act  = ~(ftrig_sync[1] ^ sync_cfg_reg[`SVOP_BIT_FRAME_POL]) & ~master_m;
   assign rtrig_fall = rtrig_prev & ~rtrig_act;
   assign ftrig_fall = ftrig_prev & ~ftrig_act;

   // Edge history
   always_ff @(posedge mclk or negedge reset_n)
   begin
      if (!reset_n)
      begin
         rtrig_prev <= 1'b0;
         ftrig_prev <= 1'b0;
      end
      else
      begin
         rtrig_prev <= rtrig_act;
         ftrig_prev <= ftrig_act;
      end
   end

   // Row address: cleared while the frame trigger is active
   always_ff @(posedge mclk or negedge reset_n)
   begin
      if (!reset_n)
         row_addr_reg <= '0;
      else if (ftrig_act)
         row_addr_reg <= '0;
      else if (rtrig_fall)
         row_addr_reg <= row_addr_reg + 1'b1;
   end
   assign row_addr = row_addr_reg;

   // Frame ready pulse on the frame trigger's falling edge
   always_ff @(posedge mclk or negedge reset_n)
   begin
      if (!reset_n)
         frame_go <= 1'b0;
      else
         frame_go <= ftrig_fall;
   end

   ////////////////////////////////////////////////////////////////////////////
   // Row trigger to first pixel delay (mclk)
   svop_trig_t trg_state;
   logic [8:0] trg_cnt;
   logic [8:0] trg_len;
   logic [8:0] trg_seen;

   // Delay figure from the integration and dark-pixel bits
   assign trg_len = `SVOP_TRIG_BASE_CYC
                  + (integ_cfg_reg[`SVOP_BIT_PFI] ? `SVOP_TRIG_PFI_CYC : 9'd0)
                  - (shift_cfg_reg[`SVOP_BIT_DARK_PIX] ? `SVOP_TRIG_DARK_CYC : 9'd0);

   // A new trigger while waiting restarts the count
   always_ff @(posedge mclk or negedge reset_n)
   begin
      if (!reset_n)
      begin
         trg_state <= TRG_IDLE;
         trg_cnt   <= 9'd0;
         row_go    <= 1'b0;
      end
      else
      begin
         row_go <= 1'b0;
         if (rtrig_fall)
         begin
            trg_state <= TRG_WAIT;
            trg_cnt   <= trg_len - 9'd1;
         end
         else
         begin
            case (trg_state)
               TRG_IDLE: ;
               TRG_WAIT:
               begin
                  if (trg_cnt == 9'd0)
                  begin
                     row_go    <= 1'b1;
                     trg_state <= TRG_IDLE;
                  end
                  else
                     trg_cnt <= trg_cnt - 9'd1;
               end
               default: trg_state <= TRG_IDLE;
            endcase
         end
      end
   end

   // Cycle count since the trigger, read only by a check
   always_ff @(posedge mclk or negedge reset_n)
   begin
      if (!reset_n)
         trg_seen <= 9'd0;
      else if (rtrig_fall)
         trg_seen <= 9'd1;
      else if (trg_state == TRG_WAIT)
         trg_seen <= trg_seen + 9'd1;
   end

   chk_trig_delay: assert property (@(posedge mclk) disable iff (!reset_n)
      (trg_state == TRG_WAIT && trg_cnt == 9'd0 && !rtrig_fall) |-> trg_seen == trg_len)
      else $error("first pixel request not at trigger delay");
   chk_row_clear: assert property (@(posedge mclk) disable iff (!reset_n)
      ftrig_act |=> row_addr == '0)
      else $error("frame trigger did not clear row address");
   chk_pfi_slave: assert property (@(posedge mclk) disable iff (!reset_n)
      !master_m |-> !pfi_active)
      else $error("partial integration active in slave mode");

   ////////////////////////////////////////////////////////////////////////////
   // Crossing into the link domain
   logic [1:0]  lrst_sync;
   logic        lrst_n;
   logic [31:0] cfg_m;
   logic [31:0] cfg_meta;
   logic [31:0] cfg_l;
   logic [1:0]  oe_sync;

   // Reset asserts at once, releases on line clock
   always_ff @(posedge line_clk2x or negedge reset_n)
   begin
      if (!reset_n)
         lrst_sync <= 2'b00;
      else
         lrst_sync <= {lrst_sync[0], 1'b1};
   end
   assign lrst_n = lrst_sync[1];

   assign cfg_m = {trail_adj_reg, sync_offs_reg, sync_cfg_reg,
                   shift_cfg_reg[7], float_cfg_reg[0], 4'h0, shift_cfg_reg[1:0]};

   // Quasi-static config bits, two flops each
   generate
      for (genvar b = 0; b < 32; b++)
      begin : g_cfg_sync
         always_ff @(posedge line_clk2x or negedge lrst_n)
         begin
            if (!lrst_n)
            begin
               cfg_meta[b] <= 1'b0;
               cfg_l[b]    <= 1'b0;
            end
            else
            begin
               cfg_meta[b] <= cfg_m[b];
               cfg_l[b]    <= cfg_meta[b];
            end
         end
      end
   endgenerate

   // Bus drive pin synchroniser
   always_ff @(posedge line_clk2x or negedge lrst_n)
   begin
      if (!lrst_n)
         oe_sync <= 2'b00;
      else
         oe_sync <= {oe_sync[0], bus_drive_en};
   end

   logic       bus_on_l;
   logic       float_l;
   logic       master_l;
   logic       pstyle_l;
   logic       pinv_l;
   logic [1:0] shift_l;
   logic [1:0] style_l;
   logic [1:0] pol_l;
   logic       drive_l;
   assign bus_on_l = cfg_l[7];
   assign float_l  = cfg_l[6];
   assign shift_l  = cfg_l[1:0];
   assign pstyle_l = cfg_l[8 + `SVOP_BIT_PCLK_STYLE];
   assign master_l = cfg_l[8 + `SVOP_BIT_MASTER];
   assign pinv_l   = cfg_l[8 + `SVOP_BIT_PCLK_INV];
   assign style_l  = {cfg_l[8 + `SVOP_BIT_FRAME_STYLE], cfg_l[8 + `SVOP_BIT_ROW_STYLE]};
   assign pol_l    = {cfg_l[8 + `SVOP_BIT_FRAME_POL], cfg_l[8 + `SVOP_BIT_ROW_POL]};
   assign drive_l  = oe_sync[1] & ~float_l;

   ////////////////////////////////////////////////////////////////////////////
   // Pixel slot timing and data path (line_clk2x)
   logic             pclk_q;
   logic             pclk_lvl;
   logic             take;
   logic [PIX_W-1:0] shifted;

   // A slot update happens while the pixel clock is low, so data moves on its rise
   assign px_ready = master_l & ~pclk_q;
   assign take     = px_valid & px_ready;

   // Shift amounts above two hold at two
   always_comb
   begin
      case (shift_l)
         2'd0:    shifted = px_data;
         2'd1:    shifted = {px_data[PIX_W-2:0], 1'b0};
         default: shifted = {px_data[PIX_W-3:0], 2'b00};
      endcase
   end

   always_ff @(posedge line_clk2x or negedge lrst_n)
   begin
      if (!lrst_n)
         pclk_q <= 1'b0;
      else
         pclk_q <= ~pclk_q;
   end

   // Free running level or one pulse per taken word
   always_ff @(posedge line_clk2x or negedge lrst_n)
   begin
      if (!lrst_n)
         pclk_lvl <= 1'b0;
      else if (pstyle_l)
         pclk_lvl <= take;
      else
         pclk_lvl <= ~pclk_q;
   end

   // Pixel register; bus off forces all lines low
   always_ff @(posedge line_clk2x or negedge lrst_n)
   begin
      if (!lrst_n)
         pix_o <= '0;
      else if (!bus_on_l)
         pix_o <= '0;
      else if (take)
         pix_o <= shifted;
   end

   assign pix_oe        = drive_l;
   assign pclk_o        = bus_on_l & (pclk_lvl ^ pinv_l);
   assign pclk_oe       = drive_l & master_l;
   assign row_sync_oe   = drive_l & master_l;
   assign frame_sync_oe = drive_l & master_l;

   ////////////////////////////////////////////////////////////////////////////
   // Row and frame sync generation, one channel each
   logic [1:0] ch_first;
   logic [1:0] ch_last;
   logic [1:0] ch_on;
   assign ch_first = {px_frame_first, px_row_first};
   assign ch_last  = {px_frame_last, px_row_last};

   generate
      for (genvar c = 0; c < 2; c++)
      begin : g_sync
         svop_ofs_t lead_cnt;
         svop_ofs_t trail_cnt;
         logic [2:0] pulse_cnt;
         svop_ofs_t lead_ofs;
         svop_ofs_t trail_ofs;
         assign lead_ofs  = cfg_l[16 + 4*c +: 3];
         assign trail_ofs = cfg_l[24 + 4*c +: 3];

         // In master mode all changes happen at slot updates, i.e. the pixel clock's active edge
         always_ff @(posedge line_clk2x or negedge lrst_n)
         begin
            if (!lrst_n)
            begin
               lead_cnt  <= '0;
               trail_cnt <= '0;
               pulse_cnt <= '0;
               ch_on[c]  <= 1'b0;
            end
            else if (!master_l)
            begin
               lead_cnt  <= '0;
               trail_cnt <= '0;
               pulse_cnt <= '0;
               ch_on[c]  <= 1'b0;
            end
            else if (!pclk_q)
            begin
               if (style_l[c])
               begin
                  // End pulse, reloaded by every last pixel
                  if (take && ch_last[c])
                     pulse_cnt <= `SVOP_SYNC_PULSE_SLOTS;
                  else if (pulse_cnt != 3'd0)
                     pulse_cnt <= pulse_cnt - 3'd1;
                  ch_on[c] <= (take && ch_last[c]) || (pulse_cnt > 3'd1);
               end
               else if (take && ch_last[c])
               begin
                  // Last pixel ends the span, later by the trail offset
                  lead_cnt <= '0;
                  if (trail_ofs == '0)
                     ch_on[c] <= 1'b0;
                  else
                  begin
                     ch_on[c]  <= 1'b1;
                     trail_cnt <= trail_ofs;
                  end
               end
               else if (take && ch_first[c])
               begin
                  // First pixel opens the span, later by the lead offset
                  if (lead_ofs == '0)
                     ch_on[c] <= 1'b1;
                  else
                     lead_cnt <= lead_ofs;
               end
               else if (lead_cnt != '0)
               begin
                  lead_cnt <= lead_cnt - 1'b1;
                  if (lead_cnt == 3'd1)
                     ch_on[c] <= 1'b1;
               end
               else if (trail_cnt != '0)
               begin
                  trail_cnt <= trail_cnt - 1'b1;
                  if (trail_cnt == 3'd1)
                     ch_on[c] <= 1'b0;
               end
            end
         end
      end
   endgenerate

   // Polarity applies in both styles; bus off switches the pins low
   assign row_sync_o   = bus_on_l & ~(ch_on[0] ^ pol_l[0]);
   assign frame_sync_o = bus_on_l & ~(ch_on[1] ^ pol_l[1]);

   ////////////////////////////////////////////////////////////////////////////
   // Link-side checks
   chk_data_float: assert property (@(posedge line_clk2x) disable iff (!lrst_n)
      (!oe_sync[1] || float_l) |-> !pix_oe)
      else $error("pixel bus driven while floated");
   // Both cycles off: the pins are gated at once, the pixel register one edge later
   chk_bus_off: assert property (@(posedge line_clk2x) disable iff (!lrst_n)
      (!bus_on_l && $past(!bus_on_l)) |->
         pix_o == '0 && !row_sync_o && !frame_sync_o && !pclk_o)
      else $error("outputs active with bus off");
   chk_slave_pins: assert property (@(posedge line_clk2x) disable iff (!lrst_n)
      !master_l |-> !row_sync_oe && !frame_sync_oe && !px_ready)
      else $error("sync pins driven in slave mode");
   chk_shift_one: assert property (@(posedge line_clk2x) disable iff (!lrst_n)
      (take && bus_on_l && shift_l == 2'd1) |=> pix_o == {$past(px_data[PIX_W-2:0]), 1'b0})
      else $error("shift by one wrong");
   chk_pclk_free: assert property (@(posedge line_clk2x) disable iff (!lrst_n)
      (!pstyle_l && $past(!pstyle_l)) |-> pclk_lvl == pclk_q)
      else $error("free running pixel clock not toggling");
   chk_pclk_ready: assert property (@(posedge line_clk2x) disable iff (!lrst_n)
      (pstyle_l && $past(pstyle_l) && pclk_lvl) |-> $past(take))
      else $error("pixel clock pulse without a word");
   chk_row_pulse: assert property (@(posedge line_clk2x) disable iff (!lrst_n)
      (style_l[0] && master_l && $rose(ch_on[0])) |-> ch_on[0] [*8])
      else $error("row pulse shorter than four slots");
   chk_frame_pulse: assert property (@(posedge line_clk2x) disable iff (!lrst_n)
      (style_l[1] && master_l && $rose(ch_on[1])) |-> ch_on[1] [*8])
      else $error("frame pulse shorter than four slots");

endmodule

/* svop_trig_model.sv */
// Purpose: Video processor model driving the slave row and frame triggers.
// Assumes: pulse is called on a falling mclk edge.
// Notes:   Idle lines rest at the inactive level given by act_lvl.
`timescale 1ns/10ps
module svop_trig_model
(
   input  wire logic mclk,
   input  wire logic act_lvl,
   output logic      row_trig,
   output logic      frame_trig
);
   logic row_on = 1'b0;
   logic frame_on = 1'b0;

   // Pin level follows the polarity the controller programmed
   assign row_trig   = row_on ~^ act_lvl;
   assign frame_trig = frame_on ~^ act_lvl;

   ////////////////////////////////////////////////////////////
   // Row held three cycles; frame two longer, so it falls inside the window
   task automatic pulse(input logic with_frame);
      row_on = 1'b1;
      frame_on = with_frame;
      repeat (3) @(negedge mclk);
      row_on = 1'b0;
      repeat (2) @(negedge mclk);
      frame_on = 1'b0;
   endtask
endmodule

/* svop_video_port_tb.sv */
// Purpose: Self-checking bench of the sensor video output port.
// Assumes: Inputs change on falling edges; link clock 64 ns, offset phase.
// Notes:   Trigger delay is judged in a window wide enough for the synchroniser.
`timescale 1ns/10ps
module svop_video_port_tb;
   logic       mclk = 0;
   logic       lclk = 0;
   logic       reset_n = 0;
   logic [7:0] addr = 0;
   logic [7:0] wdata = 0;
   logic       wr = 0;
   logic       drive_en = 1;
   logic       valid = 0;
   logic [9:0] data = 0;
   logic       first = 0;
   logic       last = 0;
   logic       pol = 1;
   logic [7:0] rdata;
   logic [9:0] pix;
   logic [8:0] row_addr;
   logic       ready, pix_oe, pclk_o, pclk_oe, rs_o, rs_oe, fs_o, fs_oe, row_go, pfi;
   logic       rtrig, ftrig;
   logic       fgo;
   int         fgo_n = 0;
   int         failures = 0;
   int         check_count = 0;
   wire logic  rs_pin = rs_oe ? rs_o : rtrig;
   wire logic  fs_pin = fs_oe ? fs_o : ftrig;

   // Clocks: link edges meet mclk edges once every 160 ns
   always #10 mclk = ~mclk;
   always #32 lclk = ~lclk;

   // Frame ready pulses, counted away from the launching edge
   always @(negedge mclk)
      if (fgo === 1'b1) fgo_n++;

   svop_video_port i_svop_video_port (.mclk(mclk), .reset_n(reset_n), .line_clk2x(lclk),
      .reg_addr(addr), .reg_wdata(wdata), .reg_wr(wr), .reg_rdata(rdata),
      .bus_drive_en(drive_en), .px_valid(valid), .px_ready(ready), .px_data(data),
      .px_row_first(first), .px_row_last(last), .px_frame_first(first),
      .px_frame_last(last), .pix_o(pix), .pix_oe(pix_oe), .pclk_o(pclk_o),
      .pclk_oe(pclk_oe), .row_sync_i(rs_pin), .row_sync_o(rs_o), .row_sync_oe(rs_oe),
      .frame_sync_i(fs_pin), .frame_sync_o(fs_o), .frame_sync_oe(fs_oe),
      .row_go(row_go), .frame_go(fgo), .row_addr(row_addr), .pfi_active(pfi));

   svop_trig_model i_svop_trig_model (.mclk(mclk), .act_lvl(pol), .row_trig(rtrig),
      .frame_trig(ftrig));

   ////////////////////////////////////////////////////////////
   // Compare and count
   task automatic chk(input string what, input logic [9:0] exp, input logic [9:0] got);
      check_count++;
      if (got !== exp)
      begin
         failures++;
         $display("FAIL %s expected %h seen %h", what, exp, got);
      end
   endtask

   task automatic finish_test;
      $display("checks %0d failures %0d", check_count, failures);
      if (failures == 0 && check_count > 0)
         $display("No errors found");
      else
         $display("Errors were found");
      $finish;
   endtask

   // Register port: write strobe lasts one cycle
   task automatic wr_reg(input logic [7:0] a, input logic [7:0] d);
      @(negedge mclk);
      addr = a;
      wdata = d;
      wr = 1;
      @(negedge mclk);
      wr = 0;
   endtask

   task automatic rd_reg(input logic [7:0] a, output logic [7:0] d);
      @(negedge mclk);
      addr = a;
      repeat (2) @(negedge mclk);
      d = rdata;
   endtask

   // Row trigger, then count cycles to the first-pixel request
   task automatic trig(input logic fr, input int x);
      int         n;
      logic [8:0] ra;
      n = 0;
      ra = row_addr;
      @(negedge mclk);
      fork
         i_svop_trig_model.pulse(fr);
         while (row_go !== 1'b1 && n < 400)
         begin
            @(negedge mclk);
            n++;
         end
      join
      chk("row_go_delay", 10'd1, {9'd0, n >= x + 4 && n <= x + 8});
      if (!fr)
         chk("row_addr", {1'b0, ra + 9'd1}, {1'b0, row_addr});
   endtask

   // Offer one word; held until taken at a rising link edge
   task automatic px(input logic [9:0] d, input logic f, input logic l);
      @(negedge lclk);
      valid = 1;
      data = d;
      first = f;
      last = l;
      while (ready !== 1'b1) @(negedge lclk);
      @(posedge lclk);
      @(negedge lclk);
      valid = 0;
   endtask

   ////////////////////////////////////////////////////////////
   // Main sequence
   initial
   begin
      logic [7:0] r;
      static logic [7:0] ra_t[7] = '{8'h15, 8'h51, 8'h52, 8'h53, 8'h54, 8'h55, 8'h60};
      static logic [7:0] rv_t[7] = '{8'h08, 8'h08, 8'h00, 8'h0C, 8'hF0, 8'h00, 8'h00};
      static int         xs[3] = '{183, 146, 138};
      repeat (16) @(negedge mclk);
      reset_n = 1;
      repeat (6) @(negedge lclk);
      for (int i = 0; i < 7; i++)
      begin
         rd_reg(ra_t[i], r);
         chk("reset_val", {2'b0, rv_t[i]}, {2'b0, r});
      end
      chk("slave_oe", 10'd0, {8'd0, rs_oe, fs_oe});
      chk("pfi_slave", 10'd0, {9'd0, pfi});
      wr_reg(8'h52, 8'h35);
      wr_reg(8'h60, 8'h35);
      rd_reg(8'h52, r);
      chk("rw_reg", 10'h035, {2'b0, r});
      rd_reg(8'h60, r);
      chk("unmapped", 10'h000, {2'b0, r});
      wr_reg(8'h52, 8'h00);
      // Delay table: partial integration, plain, dark pixels
      for (int i = 0; i < 3; i++)
      begin
         wr_reg(8'h15, i == 0 ? 8'h08 : 8'h00);
         wr_reg(8'h54, i == 2 ? 8'hF4 : 8'hF0);
         trig(1'b0, xs[i]);
      end
      trig(1'b1, 138);
      chk("row_addr_clr", 10'd1, {9'd0, row_addr <= 9'd1});
      chk("frame_go", 10'd1, 10'(fgo_n));
      // Active-low triggers; let the level change drain first
      wr_reg(8'h53, 8'h00);
      pol = 0;
      repeat (200) @(negedge mclk);
      trig(1'b0, 138);
      // Master mode, level styles, free clock, shift amounts zero to two
      wr_reg(8'h15, 8'h08);
      wr_reg(8'h53, 8'h2C);
      chk("pfi_master", 10'd1, {9'd0, pfi});
      for (int s = 0; s < 3; s++)
      begin
         wr_reg(8'h54, 8'hF0 | 8'(s));
         repeat (8) @(negedge lclk);
         px(10'h2A7, 1, 0);
         chk("pix_o", 10'(10'h2A7 << s), pix);
         chk("first_slot", 10'h00F, {6'd0, pclk_o, rs_o, fs_o, pix_oe});
         @(negedge lclk);
         chk("pclk_free", 10'd0, {9'd0, pclk_o});
         px(10'h155, 0, 1);
         repeat (4) @(negedge lclk);
         chk("sync_end", 10'd0, {8'd0, rs_o, fs_o});
      end
      // Pulse styles with data-ready pixel clock
      wr_reg(8'h53, 8'h3F);
      repeat (8) @(negedge lclk);
      px(10'h0F0, 0, 1);
      chk("ready_pclk", 10'd1, {9'd0, pclk_o});
      repeat (6) @(negedge lclk);
      chk("pulses", 10'd6, {7'd0, rs_o, fs_o, pclk_o});
      // Bus off, float bit, drive pin
      wr_reg(8'h54, 8'h70);
      repeat (8) @(negedge lclk);
      chk("bus_off", 10'd0, pix);
      wr_reg(8'h55, 8'h01);
      repeat (8) @(negedge lclk);
      chk("float", 10'd0, {7'd0, pix_oe, pclk_oe, rs_oe});
      wr_reg(8'h55, 8'h00);
      drive_en = 0;
      repeat (8) @(negedge lclk);
      chk("drive_pin", 10'd0, {8'd0, pix_oe, fs_oe});
      finish_test();
   end

   // Watchdog well beyond the expected run
   initial
   begin
      #400000;
      failures++;
      finish_test();
   end
endmodule
